// [hdl/lock_mute_pkg.sv]
/*
 * constants shared by the lock/mute/bypass control block and its word fifo.
 * assumes a single 25 MHz system clock and a 20-bit recovered word.
 */
package lock_mute_pkg;
   localparam int unsigned CLK_HZ       = 25000000;
   localparam int unsigned WORD_BITS    = 20;
   localparam int unsigned FIFO_DEPTH   = 8;
   localparam int unsigned SYNC_STAGES  = 3;
   localparam int unsigned BIT_CNT_W    = 5;
   localparam logic [4:0]  BIT_LAST     = 5'h13;
   localparam logic [4:0]  WCLK_LAST    = 5'h13;
   localparam logic [4:0]  WCLK_FALL    = 5'h0A;
   localparam logic [19:0] WORD_RESET   = 20'h00000;
   // index of each synchronised pin in the sync vector
   localparam int unsigned PIN_SERIAL   = 0;
   localparam int unsigned PIN_CARRIER  = 1;
   localparam int unsigned PIN_PHASE    = 2;
   localparam int unsigned PIN_RECLOCK  = 3;
   localparam int unsigned PIN_COUNT    = 4;
endpackage

// [hdl/word_fifo_if.sv]
/*
 * valid/ready carrier between the deserialiser and the word fifo, and
 * between the fifo and the parallel output stage.
 * assumes both sides run on the same clock.
 */
`timescale 1ns/100ps
interface word_fifo_if #(parameter int unsigned WIDTH = 20);
   logic             wr_valid;
   logic             wr_ready;
   logic [WIDTH-1:0] wr_data;
   logic             rd_valid;
   logic             rd_ready;
   logic [WIDTH-1:0] rd_data;

   modport fifo (input wr_valid, input wr_data, output wr_ready,
                 output rd_valid, output rd_data, input rd_ready);
   modport user (output wr_valid, output wr_data, input wr_ready,
                 input rd_valid, input rd_data, output rd_ready);
endinterface

// [hdl/word_fifo.sv]
/*
 * synchronous word fifo with valid/ready on both sides.
 * assumes one clock and a synchronous active-high reset; depth >= 2.
 */
`timescale 1ns/100ps
module word_fifo #(
   parameter int unsigned WIDTH = 20,
   parameter int unsigned DEPTH = 8
) (
   // clock and reset
   input  wire logic  sys_clk_i,
   input  wire logic  rst_i,
   // both fifo ports
   word_fifo_if.fifo  port_if
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    wr_ptr_nxt;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW-1:0]    rd_ptr_nxt;
   logic [AW:0]      count_r;
   logic [AW:0]      count_nxt;
   logic             push;
   logic             pop;

   assign port_if.wr_ready = (count_r != (AW+1)'(DEPTH));
   assign port_if.rd_valid = (count_r != '0);
   assign port_if.rd_data  = mem[rd_ptr_r];
   assign push             = port_if.wr_valid && port_if.wr_ready;
   assign pop              = port_if.rd_valid && port_if.rd_ready;

   always_comb
   begin
      wr_ptr_nxt = wr_ptr_r;
      rd_ptr_nxt = rd_ptr_r;
      count_nxt  = count_r;
      if (push)
      begin
         wr_ptr_nxt = (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + AW'(1);
      end
      if (pop)
      begin
         rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + AW'(1);
      end
      if (push && !pop)
      begin
         count_nxt = count_r + (AW+1)'(1);
      end
      else if (pop && !push)
      begin
         count_nxt = count_r - (AW+1)'(1);
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end
      else
      begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         count_r  <= count_nxt;
      end
   end

   // storage needs no reset; only counted entries are ever read
   always_ff @(posedge sys_clk_i)
   begin
      if (push)
      begin
         mem[wr_ptr_r] <= port_if.wr_data;
      end
   end
endmodule // word_fifo

// [hdl/lock_mute_bypass_control.sv]
/*
 * lock indication, loss-of-lock muting of the parallel word and the
 * reclock/pass-through select of the serial loop output of a serial
 * video receiver, with a word fifo between deserialiser and output.
 * assumes the carrier-detect and phase-lock conditions arrive as pins
 * from the analog front end, and one recovered bit per system clock.
 */
// Summary of operation
// - lock output is carrier detect AND phase lock.
// - signal present and loop locked: lock high, recovered outputs valid.
// - while lock is low, parallel word holds its last presented value.
// - lock output ignores the reclock select input entirely.
// - select high: serial loop output comes through the retiming stage.
// - select low: serial input passes to loop output without retiming.
// - pass-through path is never muted by loss of lock.
// - recovered data is a 20-bit word, bit 19 most significant.
// - word updates in step with word clock; downstream captures on it.
`timescale 1ns/100ps
module lock_mute_bypass_control #(
   parameter int unsigned WORD_W = lock_mute_pkg::WORD_BITS,
   parameter int unsigned DEPTH  = lock_mute_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic              sys_clk_i,
   input  wire logic              rst_i,
   // pins from the serial source and analog front end
   input  wire logic              serial_data_in_i,
   input  wire logic              carrier_detect_i,
   input  wire logic              phase_lock_i,
   input  wire logic              reclock_sel_i,
   // serial loop output
   output logic                   serial_loop_out_o,
   // status
   output logic                   lock_o,
   output logic                   overflow_o,
   // parallel side towards the deformatter
   output logic                   word_clk_o,
   output logic [WORD_W-1:0]      data_word_o
);
   localparam int unsigned NP = lock_mute_pkg::PIN_COUNT;

   // pin synchronisers: three stages; control pins accepted once stages two and three agree
   logic [NP-1:0]          sync1_r;
   logic [NP-1:0]          sync2_r;
   logic [NP-1:0]          sync3_r;
   logic [NP-1:0]          pin_r;
   logic [NP-1:0]          pin_nxt;

   // lock and serial loop
   logic                   lock_r;
   logic                   lock_nxt;
   logic                   retime_r;
   logic                   retime_nxt;
   logic                   loop_r;
   logic                   loop_nxt;

   // deserialiser
   logic [WORD_W-1:0]      shift_r;
   logic [WORD_W-1:0]      shift_nxt;
   logic [4:0]             bit_cnt_r;
   logic [4:0]             bit_cnt_nxt;
   logic                   ovf_r;
   logic                   ovf_nxt;

   // word clock and output stage
   logic [4:0]             wclk_cnt_r;
   logic [4:0]             wclk_cnt_nxt;
   logic                   wclk_r;
   logic                   wclk_nxt;
   logic [WORD_W-1:0]      word_r;
   logic [WORD_W-1:0]      word_nxt;

   word_fifo_if #(.WIDTH(WORD_W)) fifo_if ();

   word_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .port_if   (fifo_if)
   );

   // synchroniser and input filter
   always_comb
   begin
      pin_nxt = pin_r;
      for (int i = 0; i < NP; i++)
      begin
         if (sync2_r[i] == sync3_r[i])
         begin
            pin_nxt[i] = sync3_r[i];
         end
      end
      // data may toggle every cycle; the agree filter would swallow it
      pin_nxt[lock_mute_pkg::PIN_SERIAL] = sync3_r[lock_mute_pkg::PIN_SERIAL];
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
         sync3_r <= '0;
         pin_r   <= '0;
      end
      else
      begin
         sync1_r <= {reclock_sel_i, phase_lock_i, carrier_detect_i, serial_data_in_i};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         pin_r   <= pin_nxt;
      end
   end

   // lock and serial loop path
   always_comb
   begin
      // select deliberately not in this term
      lock_nxt   = pin_r[lock_mute_pkg::PIN_CARRIER] &&
                   pin_r[lock_mute_pkg::PIN_PHASE];
      retime_nxt = pin_r[lock_mute_pkg::PIN_SERIAL];
      if (pin_r[lock_mute_pkg::PIN_RECLOCK])
      begin
         loop_nxt = retime_r;
      end
      else
      begin
         // raw third stage, no filter and no lock gating
         loop_nxt = sync3_r[lock_mute_pkg::PIN_SERIAL];
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         lock_r   <= 1'b0;
         retime_r <= 1'b0;
         loop_r   <= 1'b0;
      end
      else
      begin
         lock_r   <= lock_nxt;
         retime_r <= retime_nxt;
         loop_r   <= loop_nxt;
      end
   end

   // deserialiser: first bit received lands in the msb
   always_comb
   begin
      shift_nxt        = {shift_r[WORD_W-2:0], retime_r};
      bit_cnt_nxt      = bit_cnt_r;
      ovf_nxt          = 1'b0;
      fifo_if.wr_valid = 1'b0;
      fifo_if.wr_data  = shift_nxt;
      if (!lock_r)
      begin
         // realign on relock; words from an unlocked loop are garbage
         bit_cnt_nxt = '0;
      end
      else if (bit_cnt_r == lock_mute_pkg::BIT_LAST)
      begin
         bit_cnt_nxt      = '0;
         fifo_if.wr_valid = 1'b1;
         // the serial source cannot stall, so a refused word is dropped
         ovf_nxt          = !fifo_if.wr_ready;
      end
      else
      begin
         bit_cnt_nxt = bit_cnt_r + 5'h01;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         shift_r   <= '0;
         bit_cnt_r <= '0;
         ovf_r     <= 1'b0;
      end
      else
      begin
         shift_r   <= shift_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         ovf_r     <= ovf_nxt;
      end
   end

   // word clock divider and muted parallel output
   always_comb
   begin
      wclk_cnt_nxt     = (wclk_cnt_r == lock_mute_pkg::WCLK_LAST) ? '0 :
                         wclk_cnt_r + 5'h01;
      wclk_nxt         = (wclk_cnt_nxt < lock_mute_pkg::WCLK_FALL);
      // word changes on the falling edge so the rising edge sees it settled
      fifo_if.rd_ready = lock_r && (wclk_cnt_r == lock_mute_pkg::WCLK_FALL - 5'h01);
      word_nxt         = word_r;
      if (fifo_if.rd_ready && fifo_if.rd_valid)
      begin
         word_nxt = fifo_if.rd_data;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         wclk_cnt_r <= '0;
         wclk_r     <= 1'b0;
         word_r     <= lock_mute_pkg::WORD_RESET;
      end
      else
      begin
         wclk_cnt_r <= wclk_cnt_nxt;
         wclk_r     <= wclk_nxt;
         word_r     <= word_nxt;
      end
   end

   assign serial_loop_out_o = loop_r;
   assign lock_o            = lock_r;
   assign overflow_o        = ovf_r;
   assign word_clk_o        = wclk_r;
   assign data_word_o       = word_r;
endmodule // lock_mute_bypass_control

// [test/video_source_model.sv]
/*
 far side model: serial source sending one word msb first, and a
 deformatter that captures the parallel word.
 assumes the system clock is shared with the block.
*/
`timescale 1ns/100ps
module video_source_model (
   // clock
   input  wire logic        sys_clk_i,
   // serial source
   input  wire logic [19:0] pattern_i,
   output logic             serial_o,
   // deformatter
   input  wire logic        word_clk_i,
   input  wire logic [19:0] data_word_i,
   output logic [19:0]      captured_o
);
   logic [4:0] bit_r = 5'h00;
   initial serial_o = 1'b0;
   initial captured_o = 20'h00000;
   // one bit per cycle, changed off the sampling edge
   always @(negedge sys_clk_i)
   begin
      serial_o <= pattern_i[5'h13 - bit_r];
      bit_r <= (bit_r == 5'h13) ? 5'h00 : bit_r + 5'h01;
   end
   // capture on the rising word clock only
   always @(posedge word_clk_i)
   begin
      captured_o <= data_word_i;
   end
endmodule // video_source_model

// [test/lock_mute_chk.sv]
/*
 timing relations at the pins of the lock/mute/bypass block.
 assumes it is bound to every instance of that block.
*/
`timescale 1ns/100ps
module lock_mute_chk #(
   parameter int unsigned WORD_W = 20
) (
   input wire logic              sys_clk_i,
   input wire logic              rst_i,
   input wire logic              serial_data_in_i,
   input wire logic              carrier_detect_i,
   input wire logic              phase_lock_i,
   input wire logic              reclock_sel_i,
   input wire logic              serial_loop_out_o,
   input wire logic              lock_o,
   input wire logic              word_clk_o,
   input wire logic [WORD_W-1:0] data_word_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   AST_LOCK_ON: assert property ((carrier_detect_i && phase_lock_i)[*6] |-> lock_o)
      else $error("lock low with both conditions");
   AST_CARRIER_OFF: assert property ((!carrier_detect_i)[*6] |-> !lock_o)
      else $error("lock high without carrier");
   AST_PHASE_OFF: assert property ((!phase_lock_i)[*6] |-> !lock_o)
      else $error("lock high without phase lock");
   AST_SEL_FREE: assert property (($stable(carrier_detect_i) && $stable(phase_lock_i))[*7]
      |-> $stable(lock_o)) else $error("lock moved on select");
   AST_BYPASS: assert property ((!reclock_sel_i)[*8]
      |-> serial_loop_out_o == $past(serial_data_in_i, 4)) else $error("bypass path wrong");
   AST_RETIME: assert property (reclock_sel_i[*8]
      |-> serial_loop_out_o == $past(serial_data_in_i, 6)) else $error("retimed path wrong");
   AST_MUTE: assert property (!lock_o |=> $stable(data_word_o))
      else $error("word moved while unlocked");
   AST_WORD_EDGE: assert property ($changed(data_word_o) |-> $fell(word_clk_o))
      else $error("word moved off the word clock");
   AST_WCLK: assert property ($fell(word_clk_o) |-> ##9 !word_clk_o ##1 word_clk_o
      ##9 word_clk_o ##1 !word_clk_o) else $error("word clock shape wrong");
endmodule // lock_mute_chk

bind lock_mute_bypass_control lock_mute_chk #(.WORD_W(WORD_W)) lock_mute_chk_i (
   .sys_clk_i, .rst_i, .serial_data_in_i, .carrier_detect_i, .phase_lock_i,
   .reclock_sel_i, .serial_loop_out_o, .lock_o, .word_clk_o, .data_word_o);

// [test/testbench.sv]
/*
 self-checking bench for the lock/mute/bypass block.
 assumes the far side model and the checker are compiled first.
*/
`timescale 1ns/100ps
module testbench;
   logic        sys_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        carrier = 1'b0;
   logic        phase = 1'b0;
   logic        sel = 1'b0;
   logic [19:0] pattern = 20'h00000;
   logic        serial;
   logic        loop_out;
   logic        lock;
   logic        wclk;
   logic [19:0] word;
   logic [19:0] cap;
   logic        ovf;
   logic        ovf_seen = 1'b0;
   int          miscompares = 0;
   int          n_compared = 0;
   int          cycles = 0;
   // carrier, phase, select, expected lock
   logic [3:0]  rows [8] = '{4'hD, 4'hF, 4'h4, 4'h8, 4'hD, 4'h6, 4'h0, 4'hA};

   lock_mute_bypass_control lock_mute_bypass_control_i (
      .sys_clk_i, .rst_i, .serial_data_in_i(serial), .carrier_detect_i(carrier),
      .phase_lock_i(phase), .reclock_sel_i(sel), .serial_loop_out_o(loop_out),
      .lock_o(lock), .overflow_o(ovf), .word_clk_o(wclk), .data_word_o(word));
   video_source_model video_source_model_i (
      .sys_clk_i, .pattern_i(pattern), .serial_o(serial), .word_clk_i(wclk),
      .data_word_i(word), .captured_o(cap));

   always #20 sys_clk_i = ~sys_clk_i;

   // rates match, so a dropped word means a stalled output stage
   always @(negedge sys_clk_i)
   begin
      if (!rst_i && ovf !== 1'b0)
         ovf_seen = 1'b1;
   end

   task automatic results;
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // a hang is cut short well past the longest wait
   always @(posedge sys_clk_i)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         miscompares++;
         results;
      end
   end

   task automatic check(input logic [19:0] got, input logic [19:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask

   // bounded: eight stale words may drain first
   task automatic wait_cap(input logic [19:0] exp);
      int n;
      n = 0;
      while (cap !== exp && n < 600)
      begin
         @(negedge sys_clk_i);
         n++;
      end
   endtask

   initial
   begin
      repeat (8) @(negedge sys_clk_i);
      rst_i = 1'b0;
      foreach (rows[i])
      begin
         {carrier, phase, sel} = rows[i][3:1];
         repeat (10) @(negedge sys_clk_i);
         check({19'h0, lock}, {19'h0, rows[i][0]}, "lock level");
      end
      pattern = 20'hFFFFF;
      {carrier, phase, sel} = 3'h7;
      wait_cap(20'hFFFFF);
      check(cap, 20'hFFFFF, "word after lock");
      // drop lock before the data changes, so no mixed word is stored
      carrier = 1'b0;
      repeat (10) @(negedge sys_clk_i);
      pattern = 20'h00000;
      sel = 1'b0;
      repeat (60) @(negedge sys_clk_i);
      check(word, 20'hFFFFF, "muted word");
      check({19'h0, loop_out}, 20'h00000, "bypass while unlocked");
      sel = 1'b1;
      repeat (10) @(negedge sys_clk_i);
      check({19'h0, loop_out}, 20'h00000, "retimed while unlocked");
      carrier = 1'b1;
      wait_cap(20'h00000);
      check(cap, 20'h00000, "word after relock");
      // toggling data: word alignment is free, so either phase of it is fine
      pattern = 20'hAAAAA;
      repeat (200) @(negedge sys_clk_i);
      check({19'h0, cap == 20'hAAAAA || cap == 20'h55555}, 20'h00001, "toggling word");
      rst_i = 1'b1;
      repeat (2) @(negedge sys_clk_i);
      check(word, 20'h00000, "word in reset");
      check({19'h0, lock}, 20'h00000, "lock in reset");
      check({19'h0, wclk}, 20'h00000, "word clock in reset");
      rst_i = 1'b0;
      repeat (10) @(negedge sys_clk_i);
      check({19'h0, lock}, 20'h00001, "lock after reset");
      check({19'h0, ovf_seen}, 20'h00000, "word dropped");
      results;
   end
endmodule // testbench
